// [bench/mdld_decoder_asserts.sv]
`timescale 1ns/1ps
module mdld_decoder_asserts import mdld_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Inputs that shape the count
  input wire logic narrow_bus,
  input wire logic [3:0] extra_cycles,
  // Decoder outputs
  input wire logic byte_ready,
  input wire mdld_dec_t dec,
  input wire logic instr_valid,
  input wire logic busy,
  input wire logic exec_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ==========
  // Busy length counter
  logic [6:0] busy_cnt_r;
  logic [6:0] busy_cnt_nxt;
  always_comb busy_cnt_nxt = busy ? busy_cnt_r + 7'h01 : 7'h00;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      busy_cnt_r <= 7'h00;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  // ==========
  // Properties
  sequence s_issue;
    instr_valid && busy && !byte_ready;
  endsequence
  sequence s_finish;
    !busy && byte_ready && exec_done ##1 !exec_done;
  endsequence
  chk_ready_busy: assert property (byte_ready != busy) else $error("ready not inverse of busy");
  chk_issue_start: assert property ($rose(busy) |-> s_issue) else $error("busy rose without issue");
  chk_busy_length: assert property ($fell(busy) |-> busy_cnt_r == dec.cycles)
    else $error("busy length differs from count");
  chk_done_follows: assert property ($fell(busy) |-> s_finish) else $error("done pulse missing");
  chk_sext_cycles: assert property (instr_valid && dec.op inside {MDLD_BYTE_SIGN_EXTEND_OP,
    MDLD_WORD_SIGN_EXTEND_OP} |-> dec.cycles == (dec.op == MDLD_BYTE_SIGN_EXTEND_OP ? 7'h02 : 7'h04))
    else $error("sign extend count wrong");
  chk_adjust_cycles: assert property (instr_valid && dec.op inside {MDLD_ASCII_ADJUST_MULTIPLY_OP,
    MDLD_ASCII_ADJUST_DIVIDE_OP} |-> dec.cycles == (dec.op == MDLD_ASCII_ADJUST_DIVIDE_OP ? 7'h0F : 7'h13))
    else $error("adjust count wrong");
  chk_smul_cycles: assert property (instr_valid && dec.op == MDLD_SIGNED_MULTIPLY_OP && !dec.mem
    |-> dec.cycles == (dec.wide ? 7'h22 : 7'h19) + ($past(extra_cycles) > 4'h3 ? 7'h03 : {3'h0, $past(extra_cycles)}))
    else $error("multiply count wrong");
  chk_udiv_cycles: assert property (instr_valid && dec.op == MDLD_UNSIGNED_DIVIDE_OP && !dec.mem
    |-> dec.cycles == (dec.wide ? 7'h26 : 7'h1D)) else $error("unsigned divide count wrong");
  chk_sdiv_range: assert property (instr_valid && dec.op == MDLD_SIGNED_DIVIDE_OP && !dec.mem
    |-> (dec.wide ? (dec.cycles >= 7'h35 && dec.cycles <= 7'h3D) : (dec.cycles >= 7'h2C && dec.cycles <= 7'h34)))
    else $error("signed divide count out of range");
  chk_logic_cycles: assert property (instr_valid && dec.op inside {MDLD_TEST_RM_OP, MDLD_AND_RM_OP,
    MDLD_OR_RM_OP} |-> dec.cycles == (!dec.mem ? 7'h03 : ($past(narrow_bus) && dec.wide ? 7'h0E : 7'h0A)))
    else $error("logic count wrong");
  chk_acc_cycles: assert property (instr_valid && dec.op == MDLD_TEST_IMM_ACC_OP
    |-> dec.cycles == (dec.wide ? 7'h04 : 7'h03)) else $error("accumulator test count wrong");
endmodule
bind mdld_decoder mdld_decoder_asserts chk (.mclk(mclk), .reset_n(reset_n), .narrow_bus(narrow_bus),
  .extra_cycles(extra_cycles), .byte_ready(byte_ready), .dec(dec), .instr_valid(instr_valid),
  .busy(busy), .exec_done(exec_done));

// [bench/mdld_decoder_tb.sv]
`timescale 1ns/1ps
module mdld_decoder_tb;
  import mdld_pkg::*;
  typedef struct {
    logic [31:0] b; logic [2:0] n; logic nb; logic [3:0] ex; mdld_op_t op; logic [6:0] cyc; logic ci; logic [15:0] imm;
  } mdld_row_t;
  logic mclk, reset_n, narrow_bus, byte_valid, byte_ready, instr_valid, illegal_op, busy, exec_done;
  logic [7:0] byte_data;
  logic [3:0] extra_cycles;
  mdld_dec_t dec, got;
  int bad_count, samples_checked, nbusy, t;
  mdld_row_t rows [20] = '{
    '{32'h98, 3'h1, 1'h0, 4'h0, MDLD_BYTE_SIGN_EXTEND_OP, 7'h02, 1'h0, 16'h0},
    '{32'h99, 3'h1, 1'h0, 4'h0, MDLD_WORD_SIGN_EXTEND_OP, 7'h04, 1'h0, 16'h0},
    '{32'h0AD4, 3'h2, 1'h0, 4'h0, MDLD_ASCII_ADJUST_MULTIPLY_OP, 7'h13, 1'h0, 16'h0},
    '{32'h0AD5, 3'h2, 1'h0, 4'h0, MDLD_ASCII_ADJUST_DIVIDE_OP, 7'h0F, 1'h0, 16'h0},
    '{32'hE8F6, 3'h2, 1'h0, 4'h0, MDLD_SIGNED_MULTIPLY_OP, 7'h19, 1'h0, 16'h0},
    '{32'hE8F7, 3'h2, 1'h0, 4'hF, MDLD_SIGNED_MULTIPLY_OP, 7'h25, 1'h0, 16'h0},
    '{32'hF0F6, 3'h2, 1'h0, 4'h0, MDLD_UNSIGNED_DIVIDE_OP, 7'h1D, 1'h0, 16'h0},
    '{32'hF0F7, 3'h2, 1'h1, 4'h0, MDLD_UNSIGNED_DIVIDE_OP, 7'h26, 1'h0, 16'h0},
    '{32'hF8F6, 3'h2, 1'h0, 4'h0, MDLD_SIGNED_DIVIDE_OP, 7'h2C, 1'h0, 16'h0},
    '{32'hF8F7, 3'h2, 1'h0, 4'hF, MDLD_SIGNED_DIVIDE_OP, 7'h3D, 1'h0, 16'h0},
    '{32'hFEC06B, 3'h3, 1'h0, 4'h0, MDLD_SIGNED_MULTIPLY_IMM_OP, 7'h16, 1'h1, 16'hFFFE},
    '{32'h12340069, 3'h4, 1'h1, 4'h3, MDLD_SIGNED_MULTIPLY_IMM_OP, 7'h24, 1'h1, 16'h1234},
    '{32'hC084, 3'h2, 1'h0, 4'h0, MDLD_TEST_RM_OP, 7'h03, 1'h0, 16'h0},
    '{32'h0085, 3'h2, 1'h1, 4'h0, MDLD_TEST_RM_OP, 7'h0E, 1'h0, 16'h0},
    '{32'h12C0F6, 3'h3, 1'h0, 4'h0, MDLD_TEST_IMM_RM_OP, 7'h04, 1'h1, 16'h0012},
    '{32'h123400F7, 3'h4, 1'h0, 4'h0, MDLD_TEST_IMM_RM_OP, 7'h0A, 1'h1, 16'h1234},
    '{32'h12A8, 3'h2, 1'h0, 4'h0, MDLD_TEST_IMM_ACC_OP, 7'h03, 1'h1, 16'h0012},
    '{32'h1234A9, 3'h3, 1'h0, 4'h0, MDLD_TEST_IMM_ACC_OP, 7'h04, 1'h1, 16'h1234},
    '{32'hC020, 3'h2, 1'h0, 4'h0, MDLD_AND_RM_OP, 7'h03, 1'h0, 16'h0},
    '{32'h000B, 3'h2, 1'h1, 4'h0, MDLD_OR_RM_OP, 7'h0E, 1'h0, 16'h0}};
  mdld_decoder uut (.mclk(mclk), .reset_n(reset_n), .narrow_bus(narrow_bus), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .extra_cycles(extra_cycles), .dec(dec),
    .instr_valid(instr_valid), .illegal_op(illegal_op), .busy(busy), .exec_done(exec_done));
  mdld_queue_model qm (.mclk(mclk), .reset_n(reset_n), .byte_ready(byte_ready), .byte_valid(byte_valid),
    .byte_data(byte_data));
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  task automatic push_bytes(input logic [31:0] b, input logic [2:0] n);
    for (int k = 0; k < n; k++) qm.push(b[8*k +: 8]);
  endtask
  // Waits for the issue, then counts busy cycles up to the done pulse
  task automatic await_issue;
    t = 0;
    while (instr_valid !== 1'h1 && t < 200) begin
      step();
      t++;
    end
    got = dec;
    nbusy = 0;
    while (busy === 1'h1 && nbusy < 100) begin
      step();
      nbusy++;
    end
  endtask
  task automatic close_out;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    close_out();
  end
  initial begin
    reset_n = 1'h0;
    narrow_bus = 1'h0;
    extra_cycles = 4'h0;
    repeat (6) step();
    check({busy, byte_ready, instr_valid, exec_done}, 4'h4);
    reset_n = 1'h1;
    foreach (rows[i]) begin
      narrow_bus = rows[i].nb;
      extra_cycles = rows[i].ex;
      push_bytes(rows[i].b, rows[i].n);
      await_issue();
      check(got.op, rows[i].op);
      check(nbusy, rows[i].cyc);
      check(exec_done, 1'h1);
      if (rows[i].ci) check(got.imm, rows[i].imm);
      check(got.flags_only, rows[i].op inside {MDLD_TEST_RM_OP, MDLD_TEST_IMM_RM_OP, MDLD_TEST_IMM_ACC_OP});
      if (rows[i].op inside {MDLD_AND_RM_OP, MDLD_OR_RM_OP}) check(got.dir_to_reg, rows[i].b[1]);
      $display("row %0d done", i);
    end
    // ==========
    // Back to back: next opcode is taken in the done cycle
    push_bytes(32'h9998, 3'h2);
    await_issue();
    step();
    check({instr_valid, dec.op}, {1'h1, MDLD_WORD_SIGN_EXTEND_OP});
    await_issue();
    check(nbusy, 7'h04);
    $display("back to back done");
    // Unknown extension and bad second byte are refused, then decoding recovers
    push_bytes(32'h0BD4C8F6, 3'h4);
    t = 0;
    nbusy = 0;
    while (t < 12) begin
      step();
      t++;
      if (busy !== 1'h0) check(busy, 1'h0);
      if (illegal_op === 1'h1) nbusy++;
    end
    check(nbusy, 2);
    push_bytes(32'h98, 3'h1);
    await_issue();
    check(nbusy, 7'h02);
    $display("refusal done");
    // Slow queue, then reset in mid divide
    extra_cycles = 4'h2;
    push_bytes(32'hF7, 3'h1);
    repeat (4) step();
    push_bytes(32'hE8, 3'h1);
    await_issue();
    check(nbusy, 7'h24);
    push_bytes(32'hF8F7, 3'h2);
    repeat (10) step();
    reset_n = 1'h0;
    repeat (3) step();
    check({busy, byte_ready}, 2'h1);
    reset_n = 1'h1;
    push_bytes(32'h99, 3'h1);
    await_issue();
    check(nbusy, 7'h04);
    $display("reset in flight done");
    close_out();
  end
endmodule

// [bench/mdld_queue_model.sv]
`timescale 1ns/1ps
module mdld_queue_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Byte stream
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] q [$];
  logic [7:0] last_b;
  logic rst_ok;
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  initial begin
    byte_valid = 1'h0;
    byte_data = 8'h00;
    last_b = 8'h00;
  end
  // ==========
  // Offer the head byte; a released bus shows the inverse of the last byte
  always @(posedge mclk) begin
    rst_ok = reset_n;
    if (byte_valid && byte_ready) begin
      q.delete(0);
    end
    #2;
    if (rst_ok && q.size() > 0) begin
      byte_valid = 1'h1;
      byte_data = q[0];
      last_b = q[0];
    end else begin
      byte_valid = 1'h0;
      byte_data = ~last_b;
    end
  end
endmodule

// [include/mdld_pkg.sv]
package mdld_pkg;

  typedef enum logic [3:0] {
    MDLD_NO_OP = 4'h0,
    MDLD_SIGNED_MULTIPLY_OP = 4'h1,
    MDLD_SIGNED_MULTIPLY_IMM_OP = 4'h2,
    MDLD_UNSIGNED_DIVIDE_OP = 4'h3,
    MDLD_SIGNED_DIVIDE_OP = 4'h4,
    MDLD_ASCII_ADJUST_MULTIPLY_OP = 4'h5,
    MDLD_ASCII_ADJUST_DIVIDE_OP = 4'h6,
    MDLD_BYTE_SIGN_EXTEND_OP = 4'h7,
    MDLD_WORD_SIGN_EXTEND_OP = 4'h8,
    MDLD_TEST_RM_OP = 4'h9,
    MDLD_TEST_IMM_RM_OP = 4'hA,
    MDLD_TEST_IMM_ACC_OP = 4'hB,
    MDLD_AND_RM_OP = 4'hC,
    MDLD_OR_RM_OP = 4'hD
  } mdld_op_t;

  typedef enum logic [2:0] {
    MDLD_ST_OPCODE = 3'h0,
    MDLD_ST_MODRM = 3'h1,
    MDLD_ST_SECOND = 3'h2,
    MDLD_ST_IMM = 3'h3,
    MDLD_ST_EXEC = 3'h4
  } mdld_state_t;

  // Result of classifying one opcode (and modifier byte when present)
  typedef struct packed {
    logic known;
    logic need_modrm;
    logic need_second;
    logic ext_ok;
    mdld_op_t op;
    logic wide;
    logic dir_to_reg;
    logic mem;
    logic flags_only;
    logic [1:0] imm_bytes;
    logic [6:0] cyc_min;
    logic [6:0] cyc_max;
  } mdld_cls_t;

  // Decoded instruction handed to the execution unit
  typedef struct packed {
    mdld_op_t op;
    logic wide;
    logic dir_to_reg;
    logic mem;
    logic flags_only;
    logic [7:0] modrm;
    logic [15:0] imm;
    logic [6:0] cycles;
  } mdld_dec_t;

  typedef struct packed {
    logic [6:0] cnt;
  } mdld_timer_st_t;

  typedef struct packed {
    mdld_state_t st;
    logic ready;
    logic busy;
    logic instr_valid;
    logic illegal;
    logic done;
    logic [7:0] opc;
    logic [1:0] imm_left;
    logic imm_hi;
    mdld_dec_t dec;
  } mdld_top_st_t;

endpackage

// [include/mdld_regs.svh]
`ifndef MDLD_REGS_SVH
`define MDLD_REGS_SVH

// Opcode patterns (bit 0 is w, bit 1 is d or s where the family has one)
`define MDLD_OPC_GROUP3_MASK 8'hFE
`define MDLD_OPC_GROUP3 8'hF6
`define MDLD_OPC_MUL_IMM_MASK 8'hFD
`define MDLD_OPC_MUL_IMM 8'h69
`define MDLD_OPC_ADJ_MUL 8'hD4
`define MDLD_OPC_ADJ_DIV 8'hD5
`define MDLD_OPC_ADJ_BASE 8'h0A
`define MDLD_OPC_BYTE_EXT 8'h98
`define MDLD_OPC_WORD_EXT 8'h99
`define MDLD_OPC_TEST_RM_MASK 8'hFE
`define MDLD_OPC_TEST_RM 8'h84
`define MDLD_OPC_TEST_ACC 8'hA8
`define MDLD_OPC_AND_MASK 8'hFC
`define MDLD_OPC_AND 8'h20
`define MDLD_OPC_OR 8'h08

// Group-three extension field codes
`define MDLD_EXT_TEST 3'h0
`define MDLD_EXT_SMUL 3'h5
`define MDLD_EXT_UDIV 3'h6
`define MDLD_EXT_SDIV 3'h7
`define MDLD_MOD_REG 2'h3

// Field positions
`define MDLD_BIT_W 0
`define MDLD_BIT_D 1
`define MDLD_MOD_HI 7
`define MDLD_MOD_LO 6
`define MDLD_EXT_HI 5
`define MDLD_EXT_LO 3

// Clock counts, min and max
`define MDLD_CYC_SMUL_RB_MIN 7'h19
`define MDLD_CYC_SMUL_RB_MAX 7'h1C
`define MDLD_CYC_SMUL_RW_MIN 7'h22
`define MDLD_CYC_SMUL_RW_MAX 7'h25
`define MDLD_CYC_SMUL_MB_MIN 7'h1F
`define MDLD_CYC_SMUL_MB_MAX 7'h22
`define MDLD_CYC_SMUL_MW_MIN 7'h28
`define MDLD_CYC_SMUL_MW_MAX 7'h2B
`define MDLD_CYC_SMULI_R_MIN 7'h16
`define MDLD_CYC_SMULI_R_MAX 7'h19
`define MDLD_CYC_SMULI_M_MIN 7'h1D
`define MDLD_CYC_SMULI_M_MAX 7'h20
`define MDLD_CYC_UDIV_RB 7'h1D
`define MDLD_CYC_UDIV_RW 7'h26
`define MDLD_CYC_UDIV_MB 7'h23
`define MDLD_CYC_UDIV_MW 7'h2C
`define MDLD_CYC_SDIV_RB_MIN 7'h2C
`define MDLD_CYC_SDIV_RB_MAX 7'h34
`define MDLD_CYC_SDIV_RW_MIN 7'h35
`define MDLD_CYC_SDIV_RW_MAX 7'h3D
`define MDLD_CYC_SDIV_MB_MIN 7'h32
`define MDLD_CYC_SDIV_MB_MAX 7'h3A
`define MDLD_CYC_SDIV_MW_MIN 7'h3B
`define MDLD_CYC_SDIV_MW_MAX 7'h43
`define MDLD_CYC_ADJ_MUL 7'h13
`define MDLD_CYC_ADJ_DIV 7'h0F
`define MDLD_CYC_BYTE_EXT 7'h02
`define MDLD_CYC_WORD_EXT 7'h04
`define MDLD_CYC_LOGIC_REG 7'h03
`define MDLD_CYC_LOGIC_MEM 7'h0A
`define MDLD_CYC_TESTI_REG 7'h04
`define MDLD_CYC_ACC_BYTE 7'h03
`define MDLD_CYC_ACC_WORD 7'h04
`define MDLD_CYC_NARROW_BUS_ADD 7'h04
`define MDLD_CYC_ONE 7'h01

`endif

// [verilog/mdld_classify.sv]
`timescale 1ns/1ps
`include "mdld_regs.svh"
module mdld_classify import mdld_pkg::*; (
  // Bytes under test
  input wire logic [7:0] opcode,
  input wire logic [7:0] modrm,
  // Variant strap
  input wire logic narrow_bus,
  // Result
  output mdld_cls_t cls
);

  logic w;
  logic mem;
  logic [2:0] ext;

  assign w = opcode[`MDLD_BIT_W];
  assign mem = modrm[`MDLD_MOD_HI:`MDLD_MOD_LO] != `MDLD_MOD_REG;
  assign ext = modrm[`MDLD_EXT_HI:`MDLD_EXT_LO];

  always_comb begin
    cls = '0;
    cls.op = MDLD_NO_OP;
    cls.wide = w;
    cls.mem = mem;
    cls.ext_ok = 1'b1;
    if ((opcode & `MDLD_OPC_GROUP3_MASK) == `MDLD_OPC_GROUP3) begin
      cls.known = 1'b1;
      cls.need_modrm = 1'b1;
      case (ext)
        `MDLD_EXT_SMUL: begin
          cls.op = MDLD_SIGNED_MULTIPLY_OP;
          cls.cyc_min = mem ? (w ? `MDLD_CYC_SMUL_MW_MIN : `MDLD_CYC_SMUL_MB_MIN)
                            : (w ? `MDLD_CYC_SMUL_RW_MIN : `MDLD_CYC_SMUL_RB_MIN);
          cls.cyc_max = mem ? (w ? `MDLD_CYC_SMUL_MW_MAX : `MDLD_CYC_SMUL_MB_MAX)
                            : (w ? `MDLD_CYC_SMUL_RW_MAX : `MDLD_CYC_SMUL_RB_MAX);
        end
        `MDLD_EXT_UDIV: begin
          cls.op = MDLD_UNSIGNED_DIVIDE_OP;
          cls.cyc_min = mem ? (w ? `MDLD_CYC_UDIV_MW : `MDLD_CYC_UDIV_MB)
                            : (w ? `MDLD_CYC_UDIV_RW : `MDLD_CYC_UDIV_RB);
          cls.cyc_max = cls.cyc_min;
        end
        `MDLD_EXT_SDIV: begin
          cls.op = MDLD_SIGNED_DIVIDE_OP;
          cls.cyc_min = mem ? (w ? `MDLD_CYC_SDIV_MW_MIN : `MDLD_CYC_SDIV_MB_MIN)
                            : (w ? `MDLD_CYC_SDIV_RW_MIN : `MDLD_CYC_SDIV_RB_MIN);
          cls.cyc_max = mem ? (w ? `MDLD_CYC_SDIV_MW_MAX : `MDLD_CYC_SDIV_MB_MAX)
                            : (w ? `MDLD_CYC_SDIV_RW_MAX : `MDLD_CYC_SDIV_RB_MAX);
        end
        `MDLD_EXT_TEST: begin
          cls.op = MDLD_TEST_IMM_RM_OP;
          cls.flags_only = 1'b1;
          cls.imm_bytes = w ? 2'h2 : 2'h1;
          cls.cyc_min = mem ? `MDLD_CYC_LOGIC_MEM : `MDLD_CYC_TESTI_REG;
          cls.cyc_max = cls.cyc_min;
        end
        default: begin
          // Other group-three members belong to another decoder
          cls.ext_ok = 1'b0;
        end
      endcase
    end else if ((opcode & `MDLD_OPC_MUL_IMM_MASK) == `MDLD_OPC_MUL_IMM) begin
      cls.known = 1'b1;
      cls.need_modrm = 1'b1;
      cls.op = MDLD_SIGNED_MULTIPLY_IMM_OP;
      cls.wide = 1'b1;
      cls.dir_to_reg = 1'b1;
      cls.imm_bytes = opcode[`MDLD_BIT_D] ? 2'h1 : 2'h2;
      cls.cyc_min = mem ? `MDLD_CYC_SMULI_M_MIN : `MDLD_CYC_SMULI_R_MIN;
      cls.cyc_max = mem ? `MDLD_CYC_SMULI_M_MAX : `MDLD_CYC_SMULI_R_MAX;
    end else if (opcode == `MDLD_OPC_ADJ_MUL || opcode == `MDLD_OPC_ADJ_DIV) begin
      cls.known = 1'b1;
      cls.need_second = 1'b1;
      cls.wide = 1'b0;
      cls.mem = 1'b0;
      cls.ext_ok = modrm == `MDLD_OPC_ADJ_BASE;
      cls.op = (opcode == `MDLD_OPC_ADJ_MUL) ? MDLD_ASCII_ADJUST_MULTIPLY_OP : MDLD_ASCII_ADJUST_DIVIDE_OP;
      cls.cyc_min = (opcode == `MDLD_OPC_ADJ_MUL) ? `MDLD_CYC_ADJ_MUL : `MDLD_CYC_ADJ_DIV;
      cls.cyc_max = cls.cyc_min;
    end else if (opcode == `MDLD_OPC_BYTE_EXT || opcode == `MDLD_OPC_WORD_EXT) begin
      cls.known = 1'b1;
      cls.mem = 1'b0;
      cls.wide = opcode == `MDLD_OPC_WORD_EXT;
      cls.op = cls.wide ? MDLD_WORD_SIGN_EXTEND_OP : MDLD_BYTE_SIGN_EXTEND_OP;
      cls.cyc_min = cls.wide ? `MDLD_CYC_WORD_EXT : `MDLD_CYC_BYTE_EXT;
      cls.cyc_max = cls.cyc_min;
    end else if ((opcode & `MDLD_OPC_TEST_RM_MASK) == `MDLD_OPC_TEST_RM) begin
      cls.known = 1'b1;
      cls.need_modrm = 1'b1;
      cls.op = MDLD_TEST_RM_OP;
      cls.flags_only = 1'b1;
      cls.cyc_min = mem ? `MDLD_CYC_LOGIC_MEM : `MDLD_CYC_LOGIC_REG;
      cls.cyc_max = cls.cyc_min;
    end else if ((opcode & `MDLD_OPC_TEST_RM_MASK) == `MDLD_OPC_TEST_ACC) begin
      cls.known = 1'b1;
      cls.mem = 1'b0;
      cls.op = MDLD_TEST_IMM_ACC_OP;
      cls.flags_only = 1'b1;
      cls.imm_bytes = w ? 2'h2 : 2'h1;
      cls.cyc_min = w ? `MDLD_CYC_ACC_WORD : `MDLD_CYC_ACC_BYTE;
      cls.cyc_max = cls.cyc_min;
    end else if ((opcode & `MDLD_OPC_AND_MASK) == `MDLD_OPC_AND ||
                 (opcode & `MDLD_OPC_AND_MASK) == `MDLD_OPC_OR) begin
      cls.known = 1'b1;
      cls.need_modrm = 1'b1;
      cls.op = ((opcode & `MDLD_OPC_AND_MASK) == `MDLD_OPC_AND) ? MDLD_AND_RM_OP : MDLD_OR_RM_OP;
      cls.dir_to_reg = opcode[`MDLD_BIT_D];
      cls.cyc_min = mem ? `MDLD_CYC_LOGIC_MEM : `MDLD_CYC_LOGIC_REG;
      cls.cyc_max = cls.cyc_min;
    end
    // Byte-wide bus needs a second transfer for every word memory access
    if (narrow_bus && cls.wide && cls.mem && cls.known) begin
      cls.cyc_min = cls.cyc_min + `MDLD_CYC_NARROW_BUS_ADD;
      cls.cyc_max = cls.cyc_max + `MDLD_CYC_NARROW_BUS_ADD;
    end
  end

endmodule

// [verilog/mdld_cycle_timer.sv]
`timescale 1ns/1ps
`include "mdld_regs.svh"
module mdld_cycle_timer import mdld_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Control
  input wire logic load,
  input wire logic [6:0] count,
  // Status
  output logic last
);

  mdld_timer_st_t s_r;
  mdld_timer_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.cnt = count;
    end else if (s_r.cnt != 7'h00) begin
      s_nxt.cnt = s_r.cnt - `MDLD_CYC_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign last = s_r.cnt == `MDLD_CYC_ONE;

endmodule

// [verilog/mdld_decoder.sv]
`timescale 1ns/1ps
`include "mdld_regs.svh"
module mdld_decoder import mdld_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Variant strap, high on the byte-wide bus part
  input wire logic narrow_bus,
  // Instruction byte stream from the prefetch queue
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  // Data-dependent extra clocks from the execution unit
  input wire logic [3:0] extra_cycles,
  // Decoded instruction towards the execution unit
  output mdld_dec_t dec,
  output logic instr_valid,
  output logic illegal_op,
  output logic busy,
  output logic exec_done
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Pick a count inside the documented range from the data-dependent hint
  function automatic logic [6:0] pick_cycles(input logic [6:0] lo, input logic [6:0] hi,
                                             input logic [3:0] extra);
    logic [6:0] span;
    logic [6:0] ext7;
    span = hi - lo;
    ext7 = {3'h0, extra};
    pick_cycles = lo + ((ext7 > span) ? span : ext7);
  endfunction

  // ==========================================================================
  // Classification and timing
  // ==========================================================================
  mdld_top_st_t s_r;
  mdld_top_st_t s_nxt;
  mdld_cls_t cls;
  logic [7:0] cls_opcode;
  logic take;
  logic timer_last;
  logic timer_load;

  assign take = byte_valid && s_r.ready;
  assign cls_opcode = (s_r.st == MDLD_ST_OPCODE) ? byte_data : s_r.opc;

  mdld_classify u_classify (
    .opcode(cls_opcode),
    .modrm(byte_data),
    .narrow_bus(narrow_bus),
    .cls(cls)
  );

  assign timer_load = (s_nxt.st == MDLD_ST_EXEC) && (s_r.st != MDLD_ST_EXEC);

  mdld_cycle_timer u_timer (
    .mclk(mclk),
    .reset_n(reset_n),
    .load(timer_load),
    .count(s_nxt.dec.cycles),
    .last(timer_last)
  );

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    s_nxt = s_r;
    s_nxt.instr_valid = 1'b0;
    s_nxt.illegal = 1'b0;
    s_nxt.done = 1'b0;
    case (s_r.st)
      MDLD_ST_OPCODE: begin
        if (take) begin
          s_nxt.opc = byte_data;
          s_nxt.dec = '0;
          s_nxt.dec.op = cls.op;
          s_nxt.dec.wide = cls.wide;
          s_nxt.dec.dir_to_reg = cls.dir_to_reg;
          s_nxt.dec.flags_only = cls.flags_only;
          s_nxt.imm_hi = 1'b0;
          if (!cls.known) begin
            s_nxt.illegal = 1'b1;
          end else if (cls.need_modrm) begin
            s_nxt.st = MDLD_ST_MODRM;
          end else if (cls.need_second) begin
            s_nxt.st = MDLD_ST_SECOND;
          end else begin
            // Single-byte forms never touch memory, so mod is irrelevant here
            s_nxt.dec.mem = 1'b0;
            s_nxt.dec.cycles = pick_cycles(cls.cyc_min, cls.cyc_max, extra_cycles);
            s_nxt.imm_left = cls.imm_bytes;
            s_nxt.st = (cls.imm_bytes != 2'h0) ? MDLD_ST_IMM : MDLD_ST_EXEC;
          end
        end
      end
      MDLD_ST_MODRM: begin
        if (take) begin
          s_nxt.dec.modrm = byte_data;
          s_nxt.dec.op = cls.op;
          s_nxt.dec.mem = cls.mem;
          s_nxt.dec.flags_only = cls.flags_only;
          s_nxt.dec.cycles = pick_cycles(cls.cyc_min, cls.cyc_max, extra_cycles);
          s_nxt.imm_left = cls.imm_bytes;
          if (!cls.ext_ok) begin
            s_nxt.illegal = 1'b1;
            s_nxt.st = MDLD_ST_OPCODE;
          end else begin
            s_nxt.st = (cls.imm_bytes != 2'h0) ? MDLD_ST_IMM : MDLD_ST_EXEC;
          end
        end
      end
      MDLD_ST_SECOND: begin
        if (take) begin
          s_nxt.dec.cycles = pick_cycles(cls.cyc_min, cls.cyc_max, extra_cycles);
          s_nxt.st = cls.ext_ok ? MDLD_ST_EXEC : MDLD_ST_OPCODE;
          s_nxt.illegal = !cls.ext_ok;
        end
      end
      MDLD_ST_IMM: begin
        if (take) begin
          // Low byte first; a lone byte is sign-extended for every form
          if (!s_r.imm_hi) begin
            s_nxt.dec.imm = {{8{byte_data[7]}}, byte_data};
          end else begin
            s_nxt.dec.imm = {byte_data, s_r.dec.imm[7:0]};
          end
          s_nxt.imm_hi = 1'b1;
          s_nxt.imm_left = s_r.imm_left - 2'h1;
          if (s_r.imm_left == 2'h1) begin
            s_nxt.st = MDLD_ST_EXEC;
          end
        end
      end
      MDLD_ST_EXEC: begin
        if (timer_last) begin
          s_nxt.st = MDLD_ST_OPCODE;
          s_nxt.done = 1'b1;
        end
      end
      default: begin
        s_nxt.st = MDLD_ST_OPCODE;
      end
    endcase
    if (s_nxt.st == MDLD_ST_EXEC && s_r.st != MDLD_ST_EXEC) begin
      s_nxt.instr_valid = 1'b1;
    end
    // Stall the queue for the full count so no byte slips in mid-operation
    s_nxt.busy = s_nxt.st == MDLD_ST_EXEC;
    s_nxt.ready = s_nxt.st != MDLD_ST_EXEC;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.st <= MDLD_ST_OPCODE;
      s_r.ready <= 1'b1;
      s_r.dec.op <= MDLD_NO_OP;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign byte_ready = s_r.ready;
  assign dec = s_r.dec;
  assign instr_valid = s_r.instr_valid;
  assign illegal_op = s_r.illegal;
  assign busy = s_r.busy;
  assign exec_done = s_r.done;

endmodule
